// >>> design/port_b_cfg_if.sv
// Configuration words and decoded pin functions passed between the block's modules
`timescale 1ns/100ps
`default_nettype none

interface port_b_cfg_if;
    import port_b_mux_pkg::*;

    logic [31:0] func_word;
    logic [31:0] alt_word;
    pin_func_t   pin_func [HI_PIN_COUNT];

    modport regs   (output func_word, output alt_word, input pin_func);
    modport decode (input func_word, input alt_word, output pin_func);
endinterface

`default_nettype wire

// >>> design/port_b_func_decode.sv
// Decode of register state into the function of each upper port B pin
`timescale 1ns/100ps
`default_nettype none

module port_b_func_decode
    import port_b_mux_pkg::*;
(
    port_b_cfg_if.decode cfg
);
    logic [HI_PIN_COUNT-1:0] sel;
    logic                    bus_en;
    logic                    clk_out_alt;
    logic                    timer_alt;
    logic                    ss_alt;

    assign sel       = cfg.func_word[HI_PIN_FIRST +: HI_PIN_COUNT];
    assign bus_en    = cfg.alt_word[ALT_BUS_EN_BIT];
    assign clk_out_alt = cfg.alt_word[ALT_PIN12_CLK_OUT_BIT];
    assign timer_alt = cfg.alt_word[ALT_PIN15_TIMER_BIT];
    assign ss_alt    = cfg.alt_word[ALT_PIN14_SS_BIT];

    // Pin 12: bus enable outranks the clock alternate when both are set
    assign cfg.pin_func[0] = !sel[0]  ? FUNC_GPIO                      // [R06]
                           : bus_en   ? FUNC_BUS_AD                    // [R07]
                           : clk_out_alt ? FUNC_CLOCK_OUT              // [R06]
                           :            FUNC_COMPARATOR;               // [R06]

    assign cfg.pin_func[1] = !sel[1] ? FUNC_GPIO                       // [R04]
                           : bus_en  ? FUNC_BUS_AD                     // [R05]
                           :           FUNC_COMPARATOR;                // [R04]

    // An alternate bit without the select bit leaves the pin as GPIO
    assign cfg.pin_func[2] = !sel[2] ? FUNC_GPIO                       // [R08]
                           : ss_alt  ? FUNC_SPI_SS                     // [R08]
                           :           FUNC_EXT_INT;                   // [R08]

    assign cfg.pin_func[3] = !sel[3]   ? FUNC_GPIO                     // [R03]
                           : timer_alt ? FUNC_TIMER_IN                 // [R03]
                           :             FUNC_EXT_INT;                 // [R03]
endmodule

`default_nettype wire

// >>> design/port_b_mux_pkg.sv
// Constants and types shared by the port B pin function select block
package port_b_mux_pkg;

    // Register word offsets (byte addresses)
    localparam logic [11:0] FUNC_SEL_OFFSET    = 12'h034;
    localparam logic [11:0] ALT_FUNC_OFFSET    = 12'h050;
    localparam logic [11:0] FUNC_STATUS_OFFSET = 12'h054;

    // Reset values and writable bits
    localparam logic [31:0] FUNC_SEL_RESET   = 32'h0000_0000;
    localparam logic [31:0] FUNC_SEL_WMASK   = 32'hffff_ffff;
    localparam logic [31:0] ALT_FUNC_RESET   = 32'h0000_0000;
    localparam logic [31:0] ALT_FUNC_WMASK   = 32'h0100_0c18;

    // Function select register layout
    localparam int SCHMITT_LSB  = 16;
    localparam int PIN_COUNT    = 16;
    localparam int HI_PIN_FIRST = 12;
    localparam int HI_PIN_COUNT = 4;

    // Alternate function register layout
    localparam int ALT_PIN15_TIMER_BIT = 24;
    localparam int ALT_BUS_EN_BIT      = 11;
    localparam int ALT_PIN12_CLK_OUT_BIT = 10;
    localparam int ALT_PIN11_PWM_BIT   = 4;
    localparam int ALT_PIN14_SS_BIT    = 3;

    // Status register: one field per upper pin, pin 12 lowest
    localparam int STATUS_FIELD_W = 4;

    typedef enum logic [2:0] {
        FUNC_GPIO,
        FUNC_EXT_INT,
        FUNC_TIMER_IN,
        FUNC_SPI_SS,
        FUNC_COMPARATOR,
        FUNC_CLOCK_OUT,
        FUNC_BUS_AD
    } pin_func_t;

endpackage

// >>> design/port_b_pin_function_select.sv
// Port B upper pin function select with APB register access and pad routing
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// (R01) Bit 16+n of the function select register enables the Schmitt input of pin n when one.
// (R02) The function select register resets to zero, so all pins start as GPIO without Schmitt.
// (R03) Pin 15 is GPIO, external interrupt 1, or timer 0 input when select and bit 24 are set.
// (R04) Pin 13 is GPIO with select clear, or comparator 1 output with select set and bus off.
// (R05) Pin 13 carries external bus address/data bit 1 when select and bus enable are set.
// (R06) Pin 12 is GPIO, comparator 0 with select alone, or clock output with the clock alternate.
// (R07) Pin 12 carries bus address/data bit 0 with bus enable and select set, whatever the clock alternate.
// (R08) Pin 14 is GPIO, external interrupt 0 with select alone, or SPI3 slave select 1 with bit 3.
module port_b_pin_function_select
    import port_b_mux_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB slave
    input  wire logic [ADDR_W-1:0]       paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // GPIO controller for pins 12..15
    input  wire logic [HI_PIN_COUNT-1:0] gpio_out,
    input  wire logic [HI_PIN_COUNT-1:0] gpio_oe,
    output logic      [HI_PIN_COUNT-1:0] gpio_in_r,
    // Peripheral sources driven onto pins
    input  wire logic                    comparator0_output,
    input  wire logic                    comparator1_output,
    input  wire logic                    clock_driver_output,
    input  wire logic                    spi3_slave_select_1,
    input  wire logic [1:0]              bus_addr_data_out,
    input  wire logic                    bus_addr_data_oe,
    // Peripheral inputs taken from pins
    output logic                         external_interrupt_0_n_r,
    output logic                         external_interrupt_1_n_r,
    output logic                         timer0_external_input_r,
    output logic      [1:0]              bus_addr_data_in_r,
    // Pads 12..15, and Schmitt enables of all 16 pins
    input  wire logic [HI_PIN_COUNT-1:0] pad_in,
    output logic      [HI_PIN_COUNT-1:0] pad_out_r,
    output logic      [HI_PIN_COUNT-1:0] pad_oe_r,
    output logic      [PIN_COUNT-1:0]    port_b_schmitt_enable_r
);
    port_b_cfg_if cfg ();

    // Bus phase decode
    logic        setup_phase;
    logic        access_done;
    logic        write_go;
    logic [9:0]  word_addr;
    logic        hit_func;
    logic        hit_alt;
    logic        hit_status;
    logic        addr_ok;
    logic        bad_access;
    logic        wr_func;
    logic        wr_alt;
    logic [31:0] status_word;
    logic [31:0] rd_mux;

    // Bus answer registers
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic        pready_nxt;
    logic        pslverr_nxt;
    logic [31:0] prdata_nxt;

    // Pad side next values
    logic [HI_PIN_COUNT-1:0] pad_out_nxt;
    logic [HI_PIN_COUNT-1:0] pad_oe_nxt;
    logic [1:0]              bus_in_nxt;
    logic                    external_interrupt_0_n_nxt;
    logic                    external_interrupt_1_n_nxt;
    logic                    timer_in_nxt;
    logic [PIN_COUNT-1:0]    schmitt_nxt;

    // Per-pin peripheral sources, pin 12 at index 0
    logic [HI_PIN_COUNT-1:0] cmp_src;
    logic [HI_PIN_COUNT-1:0] bus_src;

    // Returns {output enable, output value} for one pad
    function automatic logic [1:0] route_pad(
        input pin_func_t func,
        input logic      g_out,
        input logic      g_oe,
        input logic      cmp,
        input logic      bus_d,
        input logic      bus_oe,
        input logic      ss,
        input logic      clk_o
    );
        logic [1:0] r;
        r = 2'h0;
        case (func)
            FUNC_GPIO:       r = {g_oe, g_out};
            FUNC_EXT_INT:    r = 2'h0;
            FUNC_TIMER_IN:   r = 2'h0;
            FUNC_SPI_SS:     r = {1'b1, ss};
            FUNC_COMPARATOR: r = {1'b1, cmp};
            FUNC_CLOCK_OUT:  r = {1'b1, clk_o};
            FUNC_BUS_AD:     r = {bus_oe, bus_d};
            default:         r = 2'h0;
        endcase
        return r;
    endfunction

    // Registers
    port_b_reg_word #(
        .WIDTH (32),
        .RESET (FUNC_SEL_RESET),
        .WMASK (FUNC_SEL_WMASK)
    ) u_func_sel (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_func),
        .wdata   (pwdata),
        .wstrb   (pstrb),
        .q_r     (cfg.func_word)
    );                                                                 // [R02]

    port_b_reg_word #(
        .WIDTH (32),
        .RESET (ALT_FUNC_RESET),
        .WMASK (ALT_FUNC_WMASK)
    ) u_alt_func (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_alt),
        .wdata   (pwdata),
        .wstrb   (pstrb),
        .q_r     (cfg.alt_word)
    );

    port_b_func_decode u_decode (
        .cfg (cfg)
    );

    // APB decode: one setup cycle, then a single access cycle
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready_r;
    assign write_go    = access_done & pwrite & ~pslverr_r;
    assign word_addr   = paddr[11:2];
    assign hit_func    = (word_addr == FUNC_SEL_OFFSET[11:2]);
    assign hit_alt     = (word_addr == ALT_FUNC_OFFSET[11:2]);
    assign hit_status  = (word_addr == FUNC_STATUS_OFFSET[11:2]);
    assign addr_ok     = (paddr[1:0] == 2'h0) & (hit_func | hit_alt | hit_status);
    // Status is read-only; a write to it is answered with an error
    assign bad_access  = ~addr_ok | (pwrite & hit_status);
    assign wr_func     = write_go & hit_func;
    assign wr_alt      = write_go & hit_alt;

    for (genvar k = 0; k < HI_PIN_COUNT; k++)
    begin : g_status
        assign status_word[k*STATUS_FIELD_W +: STATUS_FIELD_W] = {1'b0, cfg.pin_func[k]};
    end
    assign status_word[31:HI_PIN_COUNT*STATUS_FIELD_W] = '0;

    assign rd_mux = hit_func   ? cfg.func_word
                  : hit_alt    ? cfg.alt_word
                  : hit_status ? status_word
                  :              32'h0000_0000;

    // Answer is prepared in setup so pready can come from a flip-flop
    assign pready_nxt  = setup_phase;
    assign pslverr_nxt = setup_phase & bad_access;
    assign prdata_nxt  = (setup_phase & ~pwrite & ~bad_access) ? rd_mux : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end
        else
        begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign prdata  = prdata_r;

    // Pad routing
    assign cmp_src = {2'h0, comparator1_output, comparator0_output};   // [R04] [R06]
    assign bus_src = {2'h0, bus_addr_data_out};                        // [R05] [R07]

    for (genvar k = 0; k < HI_PIN_COUNT; k++)
    begin : g_pad
        logic [1:0] routed;
        assign routed = route_pad(cfg.pin_func[k], gpio_out[k], gpio_oe[k], cmp_src[k],
                                  bus_src[k], bus_addr_data_oe, spi3_slave_select_1,
                                  clock_driver_output);
        assign pad_out_nxt[k] = routed[0];
        assign pad_oe_nxt[k]  = routed[1];
    end

    // Inputs not routed to a peripheral hold its idle level
    assign external_interrupt_0_n_nxt   = (cfg.pin_func[2] == FUNC_EXT_INT) ? pad_in[2] : 1'b1;   // [R08]
    assign external_interrupt_1_n_nxt   = (cfg.pin_func[3] == FUNC_EXT_INT) ? pad_in[3] : 1'b1;   // [R03]
    assign timer_in_nxt = (cfg.pin_func[3] == FUNC_TIMER_IN) & pad_in[3];         // [R03]
    assign bus_in_nxt[0] = (cfg.pin_func[0] == FUNC_BUS_AD) & pad_in[0];          // [R07]
    assign bus_in_nxt[1] = (cfg.pin_func[1] == FUNC_BUS_AD) & pad_in[1];          // [R05]

    assign schmitt_nxt = cfg.func_word[SCHMITT_LSB +: PIN_COUNT];                 // [R01]

    // Everything leaving the block is registered; the clock output therefore
    // is resampled by pclk and only useful well below half the pclk rate
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pad_out_r                <= '0;
            pad_oe_r                 <= '0;
            gpio_in_r                <= '0;
            external_interrupt_0_n_r <= 1'b1;
            external_interrupt_1_n_r <= 1'b1;
            timer0_external_input_r  <= 1'b0;
            bus_addr_data_in_r       <= 2'h0;
            port_b_schmitt_enable_r  <= '0;                            // [R02]
        end
        else
        begin
            pad_out_r                <= pad_out_nxt;
            pad_oe_r                 <= pad_oe_nxt;
            gpio_in_r                <= pad_in;
            external_interrupt_0_n_r <= external_interrupt_0_n_nxt;
            external_interrupt_1_n_r <= external_interrupt_1_n_nxt;
            timer0_external_input_r  <= timer_in_nxt;
            bus_addr_data_in_r       <= bus_in_nxt;
            port_b_schmitt_enable_r  <= schmitt_nxt;                   // [R01]
        end
    end
endmodule

`default_nettype wire

// >>> design/port_b_reg_word.sv
// One software register word with byte strobes, write mask and reset value
`timescale 1ns/100ps
`default_nettype none

module port_b_reg_word #(
    parameter int          WIDTH = 32,
    parameter logic [31:0] RESET = 32'h0000_0000,
    parameter logic [31:0] WMASK = 32'hffff_ffff
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Write port
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [WIDTH/8-1:0] wstrb,
    // Stored value
    output logic      [WIDTH-1:0] q_r
);
    logic [WIDTH-1:0] lane_mask;
    logic [WIDTH-1:0] bit_mask;
    logic [WIDTH-1:0] q_nxt;

    for (genvar b = 0; b < WIDTH / 8; b++)
    begin : g_lane
        assign lane_mask[b*8 +: 8] = {8{wstrb[b]}};
    end

    // Bits outside the mask stay at their reset value and read back as such
    assign bit_mask = lane_mask & WMASK[WIDTH-1:0];
    assign q_nxt    = (q_r & ~bit_mask) | (wdata & bit_mask);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q_r <= RESET[WIDTH-1:0];
        else if (wr_en)
            q_r <= q_nxt;
    end
endmodule

`default_nettype wire

// >>> test/port_b_mux_sva.sv
// Concurrent checks on the ports of the port B pin function select block
`timescale 1ns/100ps
`default_nettype none

module port_b_mux_sva
    import port_b_mux_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic                    pclk,
    input wire logic                    presetn,
    // APB slave
    input wire logic [ADDR_W-1:0]       paddr,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    // Pads and peripheral inputs
    input wire logic [HI_PIN_COUNT-1:0] pad_in,
    input wire logic                    external_interrupt_0_n_r,
    input wire logic                    external_interrupt_1_n_r,
    input wire logic                    timer0_external_input_r,
    input wire logic [1:0]              bus_addr_data_in_r,
    input wire logic [PIN_COUNT-1:0]    port_b_schmitt_enable_r
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence

    property p_ready_once;
        s_setup |=> s_answer;
    endproperty
    property p_misaligned;
        s_setup and (paddr[1:0] != 2'b00) |=> pready && pslverr;
    endproperty
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    property p_rdata_idle;
        !pready |-> prdata == 32'h0000_0000;
    endproperty
    // A write lands at the access edge, the decoded copy one edge later
    property p_schmitt;
        !$stable(port_b_schmitt_enable_r)
            |-> $past(psel && penable && pwrite && paddr == FUNC_SEL_OFFSET, 2);
    endproperty
    property p_external_interrupt_1;
        !external_interrupt_1_n_r |-> !$past(pad_in[3]);
    endproperty
    property p_timer;
        timer0_external_input_r |-> $past(pad_in[3]);
    endproperty
    property p_external_interrupt_0;
        !external_interrupt_0_n_r |-> !$past(pad_in[2]);
    endproperty
    property p_bus_hi;
        bus_addr_data_in_r[1] |-> $past(pad_in[1]);
    endproperty
    property p_bus_lo;
        bus_addr_data_in_r[0] |-> $past(pad_in[0]);
    endproperty

    a_ready_once: assert property (p_ready_once)
        else $error("ready not a single cycle after setup");
    a_misaligned: assert property (p_misaligned)
        else $error("misaligned access not refused");
    a_err_ready: assert property (p_err_ready)
        else $error("error without ready");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside access");
    a_schmitt: assert property (p_schmitt)
        else $error("schmitt enables changed without a write");
    a_external_interrupt_1: assert property (p_external_interrupt_1)
        else $error("interrupt 1 low while pad high");
    a_timer: assert property (p_timer)
        else $error("timer input high while pad low");
    a_external_interrupt_0: assert property (p_external_interrupt_0)
        else $error("interrupt 0 low while pad high");
    a_bus_hi: assert property (p_bus_hi)
        else $error("bus bit 1 high while pad low");
    a_bus_lo: assert property (p_bus_lo)
        else $error("bus bit 0 high while pad low");
endmodule

bind port_b_pin_function_select port_b_mux_sva #(.ADDR_W(ADDR_W)) i_sva (.*);

`default_nettype wire

// >>> test/port_b_pin_function_select_tb.sv
// Register and pad routing bench for the port B pin function select block
`timescale 1ns/100ps
`default_nettype none

module port_b_pin_function_select_tb;
    import port_b_mux_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb, gpio_out, gpio_oe, gpio_in_r, pad_in, pad_out_r, pad_oe_r;
    logic        comparator0_output, comparator1_output;
    logic        clock_driver_output, spi3_slave_select_1, bus_addr_data_oe;
    logic [1:0]  bus_addr_data_out, bus_addr_data_in_r;
    logic        external_interrupt_0_n_r, external_interrupt_1_n_r;
    logic        timer0_external_input_r;
    logic [15:0] port_b_schmitt_enable_r;
    int          failures, checked;

    // Per case: function word, alternate word, sources, status, pads, inputs
    localparam logic [31:0] FW [5] = '{32'h0, 32'h8001_f000, 32'h7ffe_f000,
                                       32'h1234_f000, 32'hffff_0000};
    localparam logic [31:0] AW [5] = '{32'h0, 32'h0, 32'h0100_0408,
                                       32'h0000_0800, 32'h0100_0c08};
    localparam logic [15:0] SRC [5] = '{16'h6236, 16'h6240, 16'h6238, 16'h6205, 16'h1d80};
    localparam logic [15:0] ST [5] = '{16'h0, 16'h1144, 16'h2345, 16'h1166, 16'h0};
    localparam logic [7:0]  PD [5] = '{8'hc4, 8'h13, 8'h77, 8'h23, 8'h3b};
    localparam logic [4:0]  SD [5] = '{5'h18, 5'h00, 5'h1c, 5'h03, 5'h18};

    port_b_pin_function_select i_dut (.*);

    always #10 pclk = ~pclk;

    task automatic complete_run();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Holds the request until ready is sampled high, bounded
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] exp_q, input logic exp_e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 16)
        begin
            failures++;
            complete_run();
        end
        if (!w)
            chk($sformatf("rdata %h", a), exp_q, prdata);
        chk($sformatf("err %h", a), {31'h0, exp_e}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        pad_in = 4'h0;
        {gpio_out, gpio_oe, comparator0_output, comparator1_output, clock_driver_output,
         spi3_slave_select_1, bus_addr_data_out, bus_addr_data_oe} = SRC[0][14:0];
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, FUNC_SEL_OFFSET, 32'h0, 32'h0, 1'b0);
        chk("schmitt", 32'h0, {16'h0, port_b_schmitt_enable_r});
        apb(1'b0, ALT_FUNC_OFFSET, 32'h0, 32'h0, 1'b0);
        apb(1'b1, ALT_FUNC_OFFSET, 32'hffff_ffff, 32'h0, 1'b0);
        apb(1'b0, ALT_FUNC_OFFSET, 32'h0, 32'h0100_0c18, 1'b0);
        // Refused: read-only status, unmapped, misaligned
        apb(1'b1, FUNC_STATUS_OFFSET, 32'hffff_ffff, 32'h0, 1'b1);
        apb(1'b0, 12'h040, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 12'h036, 32'h0, 32'h0, 1'b1);
        // Only the enabled byte lane of a write may land
        pstrb <= 4'h2;
        apb(1'b1, FUNC_SEL_OFFSET, 32'hffff_ffff, 32'h0, 1'b0);
        pstrb <= 4'hf;
        apb(1'b0, FUNC_SEL_OFFSET, 32'h0, 32'h0000_ff00, 1'b0);
        for (int k = 0; k < 5; k++)
        begin
            @(posedge pclk);
            pad_in <= {AW[k][24], 3'b011};
            {gpio_out, gpio_oe, comparator0_output, comparator1_output, clock_driver_output,
             spi3_slave_select_1, bus_addr_data_out, bus_addr_data_oe} <= SRC[k][14:0];
            apb(1'b1, FUNC_SEL_OFFSET, FW[k], 32'h0, 1'b0);
            apb(1'b1, ALT_FUNC_OFFSET, AW[k], 32'h0, 1'b0);
            repeat (3) @(posedge pclk);
            chk("pads", {24'h0, PD[k]}, {24'h0, pad_out_r, pad_oe_r});
            chk("schmitt", {16'h0, FW[k][31:16]}, {16'h0, port_b_schmitt_enable_r});
            chk("inputs", {27'h0, SD[k]}, {27'h0, external_interrupt_1_n_r, external_interrupt_0_n_r,
                timer0_external_input_r, bus_addr_data_in_r});
            chk("gpio_in", {28'h0, pad_in}, {28'h0, gpio_in_r});
            apb(1'b0, FUNC_STATUS_OFFSET, 32'h0, {16'h0, ST[k]}, 1'b0);
            apb(1'b0, FUNC_SEL_OFFSET, 32'h0, FW[k], 1'b0);
        end
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, FUNC_SEL_OFFSET, 32'h0, 32'h0, 1'b0);
        apb(1'b0, ALT_FUNC_OFFSET, 32'h0, ALT_FUNC_RESET, 1'b0);
        chk("schmitt_rst", 32'h0, {16'h0, port_b_schmitt_enable_r});
        complete_run();
    end
endmodule

`default_nettype wire
